// [include/ucrd_map.vh]
// Address map, field positions, masks and reset values of the channel register decoder.
`ifndef UCRD_MAP_VH
`define UCRD_MAP_VH

// Register addresses on the three address lines.
`define UCRD_A_HOLD      3'h0
`define UCRD_A_IER       3'h1
`define UCRD_A_ISR       3'h2
`define UCRD_A_LCR       3'h3
`define UCRD_A_MCR       3'h4
`define UCRD_A_LSR       3'h5
`define UCRD_A_MSR       3'h6
`define UCRD_A_SPR       3'h7

// Line control value that opens the enhanced register set.
`define UCRD_LCR_KEY     8'hBF
// Divisor access enable bit of the line control register.
`define UCRD_LCR_DIV     7
// Unlock bit of the enhanced feature register.
`define UCRD_EFR_UNLOCK  4

// Bits that only exist while the unlock bit is set.
`define UCRD_IER_GATE    8'hF0
`define UCRD_ISR_GATE    8'h30
`define UCRD_FCR_GATE    8'h30
`define UCRD_MCR_GATE    8'hE0
// Implemented bits of the fractional divisor; the top two are reserved.
`define UCRD_DLD_VALID   8'h3F

// Modem control bit positions.
`define UCRD_MCR_DTR     0
`define UCRD_MCR_RTS     1
`define UCRD_MCR_OP1     2
`define UCRD_MCR_OP2     3
`define UCRD_MCR_LOOP    4

// Common values.
`define UCRD_RST_VAL     8'h00
`define UCRD_ALL_ONES    8'hFF
`define UCRD_CHANNELS    4

`endif

// [logic/ucrd_chan_regs.v]
// Writable register set of one UART channel with enhanced-bit gating.
`default_nettype none
`include "ucrd_map.vh"

module ucrd_chan_regs (
  input  wire       clock,
  input  wire       rst_n,
  input  wire       wr_stb,
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] tx_data_r,
  output reg        tx_load_r,
  output wire [7:0] fifo_ctl,
  output reg        fifo_load_r,
  output wire [7:0] int_enable,
  output wire [7:0] line_ctl,
  output wire [7:0] modem_ctl,
  output wire [7:0] enh_feature,
  output wire [7:0] div_low,
  output wire [7:0] div_high,
  output wire [7:0] div_frac,
  output wire [7:0] scratch,
  output wire [7:0] resume_first,
  output wire [7:0] resume_second,
  output wire [7:0] pause_first,
  output wire [7:0] pause_second
);

  reg  [7:0] ier_r;
  reg  [7:0] fcr_r;
  reg  [7:0] lcr_r;
  reg  [7:0] mcr_r;
  reg  [7:0] efr_r;
  reg  [7:0] dll_r;
  reg  [7:0] dlm_r;
  reg  [7:0] dld_r;
  reg  [7:0] spr_r;
  reg  [7:0] res1_r;
  reg  [7:0] res2_r;
  reg  [7:0] pau1_r;
  reg  [7:0] pau2_r;

  // Mode of the overlaid map and the unlock state.
  wire       mode_enh = (lcr_r == `UCRD_LCR_KEY);
  wire       mode_std = ~lcr_r[`UCRD_LCR_DIV];
  wire       mode_div = lcr_r[`UCRD_LCR_DIV] & ~mode_enh;
  wire       unlocked = efr_r[`UCRD_EFR_UNLOCK];
  wire [7:0] open_m   = unlocked ? `UCRD_ALL_ONES : `UCRD_RST_VAL;
  wire [7:0] ier_m    = ~`UCRD_IER_GATE | open_m;
  wire [7:0] fcr_m    = ~`UCRD_FCR_GATE | open_m;
  wire [7:0] mcr_m    = ~`UCRD_MCR_GATE | open_m;
  wire [7:0] dld_m    = `UCRD_DLD_VALID & open_m;

  // Gated bits read back as zero while locked.
  assign int_enable    = ier_r & ier_m;
  assign fifo_ctl      = fcr_r & fcr_m;
  assign modem_ctl     = mcr_r & mcr_m;
  assign div_frac      = dld_r & dld_m;
  assign line_ctl      = lcr_r;
  assign enh_feature   = efr_r;
  assign div_low       = dll_r;
  assign div_high      = dlm_r;
  assign scratch       = spr_r;
  assign resume_first  = res1_r;
  assign resume_second = res2_r;
  assign pause_first   = pau1_r;
  assign pause_second  = pau2_r;

  // Write decode; locations that hold only status keep their state.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_r   <= `UCRD_RST_VAL;
      tx_load_r   <= 1'b0;
      fifo_load_r <= 1'b0;
      ier_r       <= `UCRD_RST_VAL;
      fcr_r       <= `UCRD_RST_VAL;
      lcr_r       <= `UCRD_RST_VAL;
      mcr_r       <= `UCRD_RST_VAL;
      efr_r       <= `UCRD_RST_VAL;
      dll_r       <= `UCRD_RST_VAL;
      dlm_r       <= `UCRD_RST_VAL;
      dld_r       <= `UCRD_RST_VAL;
      spr_r       <= `UCRD_RST_VAL;
      res1_r      <= `UCRD_RST_VAL;
      res2_r      <= `UCRD_RST_VAL;
      pau1_r      <= `UCRD_RST_VAL;
      pau2_r      <= `UCRD_RST_VAL;
    end else begin
      tx_load_r   <= 1'b0;
      fifo_load_r <= 1'b0;
      if (wr_stb) begin
        case (addr)
          `UCRD_A_HOLD: begin
            if (mode_std) begin
              tx_data_r <= wdata;
              tx_load_r <= 1'b1;
            end else if (mode_div) begin
              dll_r <= wdata;
            end
          end
          `UCRD_A_IER: begin
            if (mode_std) begin
              ier_r <= (wdata & ier_m) | (ier_r & ~ier_m);
            end else if (mode_div) begin
              dlm_r <= wdata;
            end
          end
          `UCRD_A_ISR: begin
            if (mode_std) begin
              fcr_r       <= (wdata & fcr_m) | (fcr_r & ~fcr_m);
              fifo_load_r <= 1'b1;
            end else if (mode_div) begin
              dld_r <= (wdata & dld_m) | (dld_r & ~dld_m);
            end else begin
              efr_r <= wdata;
            end
          end
          `UCRD_A_LCR: begin
            lcr_r <= wdata;
          end
          `UCRD_A_MCR: begin
            if (mode_enh) begin
              res1_r <= wdata;
            end else begin
              mcr_r <= (wdata & mcr_m) | (mcr_r & ~mcr_m);
            end
          end
          `UCRD_A_LSR: begin
            if (mode_enh) begin
              res2_r <= wdata;
            end
          end
          `UCRD_A_MSR: begin
            if (mode_enh) begin
              pau1_r <= wdata;
            end
          end
          default: begin
            if (mode_enh) begin
              pau2_r <= wdata;
            end else if (mode_std) begin
              spr_r <= wdata;
            end
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [logic/ucrd_register_decode.v]
// Four-channel register decoder: bus sampling, channel select, read mux and modem status.
//
// Function
// - Each channel owns a private register set.
// - Address 0 standard: receive read, transmit write.
// - Divisor mode: addresses 0-2 reach divisor bytes.
// - Key value: address 2 reaches enhanced feature.
// - Key value: addresses 4-7 reach flow characters.
// - Address 1 standard: interrupt enable read/write.
// - Upper control bits usable only when unlocked.
// - Address 2 standard: status read, FIFO write.
// - Address 3 always reaches line control.
// - Address 4 reaches modem control unless key.
// - Address 5 standard reads line status.
// - Address 6 standard reads modem status.
// - Address 7 standard is plain scratch storage.
// - Fraction bits, 8x and 4x sampling select.
// - Reset clears all four flow characters.
// - Reset clears every interrupt enable bit.
`default_nettype none
`include "ucrd_map.vh"

module ucrd_register_decode (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [3:0]  cs_n,
  input  wire [2:0]  addr,
  input  wire        wr_n,
  input  wire        rd_n,
  input  wire [7:0]  wdata,
  output reg  [7:0]  rdata_r,
  output wire        rdata_oe,
  input  wire [31:0] rx_data,
  input  wire [31:0] isr_in,
  input  wire [31:0] lsr_in,
  input  wire [3:0]  cts_n,
  input  wire [3:0]  dsr_n,
  input  wire [3:0]  ri_n,
  input  wire [3:0]  cd_n,
  output reg  [3:0]  rx_pop_r,
  output wire [31:0] tx_data,
  output wire [3:0]  tx_load,
  output wire [31:0] fifo_ctl,
  output wire [3:0]  fifo_load,
  output wire [31:0] int_enable,
  output wire [31:0] line_ctl,
  output wire [31:0] modem_ctl,
  output wire [31:0] enh_feature,
  output wire [31:0] div_low,
  output wire [31:0] div_high,
  output wire [31:0] div_frac,
  output wire [31:0] resume_first,
  output wire [31:0] resume_second,
  output wire [31:0] pause_first,
  output wire [31:0] pause_second,
  output wire [31:0] modem_status,
  output reg  [3:0]  dtr_n_r,
  output reg  [3:0]  rts_n_r,
  output reg  [3:0]  interrupt_output_enable_r,
  output reg  [3:0]  reserved_user_output_r,
  output reg  [3:0]  loopback_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus pin sampling.

  reg  [3:0]  cs_s1_r;
  reg  [3:0]  cs_s2_r;
  reg  [2:0]  a_s1_r;
  reg  [2:0]  a_s2_r;
  reg  [7:0]  d_s1_r;
  reg  [7:0]  d_s2_r;
  reg         wr_s1_r;
  reg         wr_s2_r;
  reg         wr_d_r;
  reg         rd_s1_r;
  reg         rd_s2_r;
  reg         rd_d_r;

  // Two flip-flops on every bus pin; the strobes get a third stage, compared with the second to find the falling edge.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_r <= 4'hF;
      cs_s2_r <= 4'hF;
      a_s1_r  <= 3'h0;
      a_s2_r  <= 3'h0;
      d_s1_r  <= `UCRD_RST_VAL;
      d_s2_r  <= `UCRD_RST_VAL;
      wr_s1_r <= 1'b1;
      wr_s2_r <= 1'b1;
      wr_d_r  <= 1'b1;
      rd_s1_r <= 1'b1;
      rd_s2_r <= 1'b1;
      rd_d_r  <= 1'b1;
    end else begin
      cs_s1_r <= cs_n;
      cs_s2_r <= cs_s1_r;
      a_s1_r  <= addr;
      a_s2_r  <= a_s1_r;
      d_s1_r  <= wdata;
      d_s2_r  <= d_s1_r;
      wr_s1_r <= wr_n;
      wr_s2_r <= wr_s1_r;
      wr_d_r  <= wr_s2_r;
      rd_s1_r <= rd_n;
      rd_s2_r <= rd_s1_r;
      rd_d_r  <= rd_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel select and strobes.

  reg  [1:0]  chan_idx;
  wire        chan_hit = ~&cs_s2_r;
  wire        wr_fall  = wr_d_r & ~wr_s2_r;
  wire        rd_fall  = rd_d_r & ~rd_s2_r;
  wire [4:0]  base     = {chan_idx, 3'b000};

  // Lowest selected channel wins if more than one select is low.
  always @* begin
    if (!cs_s2_r[0]) begin
      chan_idx = 2'd0;
    end else if (!cs_s2_r[1]) begin
      chan_idx = 2'd1;
    end else if (!cs_s2_r[2]) begin
      chan_idx = 2'd2;
    end else begin
      chan_idx = 2'd3;
    end
  end

  // Data are driven while a selected read is in progress.
  assign rdata_oe = chan_hit & ~rd_s2_r;

  // Mode of the selected channel.
  wire [7:0]  sel_lcr  = line_ctl[base +: 8];
  wire        sel_enh  = (sel_lcr == `UCRD_LCR_KEY);
  wire        sel_std  = ~sel_lcr[`UCRD_LCR_DIV];
  wire        sel_div  = sel_lcr[`UCRD_LCR_DIV] & ~sel_enh;
  wire        sel_unl  = enh_feature[base + `UCRD_EFR_UNLOCK];
  wire [7:0]  isr_m    = sel_unl ? `UCRD_ALL_ONES : ~`UCRD_ISR_GATE;

  // Read side effects: popping the receive byte and clearing modem deltas.
  wire        rd_take  = rd_fall & chan_hit;
  wire        pop_now  = rd_take & sel_std & (a_s2_r == `UCRD_A_HOLD);
  wire        msr_now  = rd_take & sel_std & (a_s2_r == `UCRD_A_MSR);

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel register sets and modem status.

  wire [31:0] scratch;
  reg  [15:0] mdm_s1_r;
  reg  [15:0] mdm_s2_r;

  // Synchronise all sixteen modem inputs as one vector.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mdm_s1_r <= 16'hFFFF;
      mdm_s2_r <= 16'hFFFF;
    end else begin
      mdm_s1_r <= {cd_n, ri_n, dsr_n, cts_n};
      mdm_s2_r <= mdm_s1_r;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `UCRD_CHANNELS; g = g + 1) begin : chan
      wire [7:0] modem_control = modem_ctl[8*g +: 8];
      wire [3:0] pin_lvl;
      wire [3:0] lvl;
      reg  [3:0] prev_r;
      reg  [3:0] delta_r;

      // Each channel gets its own strobe so no write leaks across.
      ucrd_chan_regs u_regs (
        .clock         (clock),
        .rst_n         (rst_n),
        .wr_stb        (wr_fall & chan_hit & (chan_idx == g)),
        .addr          (a_s2_r),
        .wdata         (d_s2_r),
        .tx_data_r     (tx_data[8*g +: 8]),
        .tx_load_r     (tx_load[g]),
        .fifo_ctl      (fifo_ctl[8*g +: 8]),
        .fifo_load_r   (fifo_load[g]),
        .int_enable    (int_enable[8*g +: 8]),
        .line_ctl      (line_ctl[8*g +: 8]),
        .modem_ctl     (modem_ctl[8*g +: 8]),
        .enh_feature   (enh_feature[8*g +: 8]),
        .div_low       (div_low[8*g +: 8]),
        .div_high      (div_high[8*g +: 8]),
        .div_frac      (div_frac[8*g +: 8]),
        .scratch       (scratch[8*g +: 8]),
        .resume_first  (resume_first[8*g +: 8]),
        .resume_second (resume_second[8*g +: 8]),
        .pause_first   (pause_first[8*g +: 8]),
        .pause_second  (pause_second[8*g +: 8])
      );

      // Active levels of CTS, DSR, RI and CD; loopback feeds back the outputs.
      assign pin_lvl = ~{mdm_s2_r[12 + g], mdm_s2_r[8 + g], mdm_s2_r[4 + g], mdm_s2_r[g]};
      assign lvl     = modem_control[`UCRD_MCR_LOOP] ?
                       {modem_control[`UCRD_MCR_OP2], modem_control[`UCRD_MCR_OP1],
                        modem_control[`UCRD_MCR_DTR], modem_control[`UCRD_MCR_RTS]} : pin_lvl;

      // Change flags: a change in the clearing cycle stays set.
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          prev_r  <= 4'h0;
          delta_r <= 4'h0;
        end else begin
          prev_r  <= lvl;
          delta_r <= (delta_r & ~{4{msr_now & (chan_idx == g)}}) | (lvl ^ prev_r);
        end
      end

      assign modem_status[8*g +: 8] = {lvl, delta_r};

      // Modem pins; both request outputs go inactive during loopback.
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          dtr_n_r[g]                   <= 1'b1;
          rts_n_r[g]                   <= 1'b1;
          interrupt_output_enable_r[g] <= 1'b0;
          reserved_user_output_r[g]    <= 1'b0;
          loopback_r[g]                <= 1'b0;
        end else begin
          dtr_n_r[g]                   <= ~modem_control[`UCRD_MCR_DTR] | modem_control[`UCRD_MCR_LOOP];
          rts_n_r[g]                   <= ~modem_control[`UCRD_MCR_RTS] | modem_control[`UCRD_MCR_LOOP];
          interrupt_output_enable_r[g] <= modem_control[`UCRD_MCR_OP2];
          reserved_user_output_r[g]    <= modem_control[`UCRD_MCR_OP1];
          loopback_r[g]                <= modem_control[`UCRD_MCR_LOOP];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  reg  [7:0]  rd_mux;

  // Select the location of the selected channel for the current mode.
  always @* begin
    rd_mux = `UCRD_RST_VAL;
    case (a_s2_r)
      `UCRD_A_HOLD: begin
        if (sel_std) begin
          rd_mux = rx_data[base +: 8];
        end else if (sel_div) begin
          rd_mux = div_low[base +: 8];
        end
      end
      `UCRD_A_IER: begin
        if (sel_std) begin
          rd_mux = int_enable[base +: 8];
        end else if (sel_div) begin
          rd_mux = div_high[base +: 8];
        end
      end
      `UCRD_A_ISR: begin
        if (sel_std) begin
          rd_mux = isr_in[base +: 8] & isr_m;
        end else if (sel_div) begin
          rd_mux = div_frac[base +: 8];
        end else begin
          rd_mux = enh_feature[base +: 8];
        end
      end
      `UCRD_A_LCR: begin
        rd_mux = sel_lcr;
      end
      `UCRD_A_MCR: begin
        rd_mux = sel_enh ? resume_first[base +: 8] : modem_ctl[base +: 8];
      end
      `UCRD_A_LSR: begin
        if (sel_enh) begin
          rd_mux = resume_second[base +: 8];
        end else if (sel_std) begin
          rd_mux = lsr_in[base +: 8];
        end
      end
      `UCRD_A_MSR: begin
        if (sel_enh) begin
          rd_mux = pause_first[base +: 8];
        end else if (sel_std) begin
          rd_mux = modem_status[base +: 8];
        end
      end
      default: begin
        if (sel_enh) begin
          rd_mux = pause_second[base +: 8];
        end else if (sel_std) begin
          rd_mux = scratch[base +: 8];
        end
      end
    endcase
  end

  // Capture read data at the start of a read and pulse the pop strobe.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r  <= `UCRD_RST_VAL;
      rx_pop_r <= 4'h0;
    end else begin
      rx_pop_r <= 4'h0;
      if (rd_take) begin
        rdata_r <= rd_mux;
      end
      if (pop_now) begin
        rx_pop_r[chan_idx] <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/ucrd_decode_asserts.sv]
// Concurrent checks on the ports of the four-channel register decoder.
`default_nettype none
module ucrd_decode_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [3:0]  cs_n,
  input wire logic [2:0]  addr,
  input wire logic        rd_n,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata_r,
  input wire logic        rdata_oe,
  input wire logic [3:0]  cts_n,
  input wire logic [3:0]  rx_pop_r,
  input wire logic [31:0] tx_data,
  input wire logic [3:0]  tx_load,
  input wire logic [3:0]  fifo_load,
  input wire logic [31:0] fifo_ctl,
  input wire logic [31:0] int_enable,
  input wire logic [31:0] line_ctl,
  input wire logic [31:0] modem_ctl,
  input wire logic [31:0] enh_feature,
  input wire logic [31:0] div_frac,
  input wire logic [31:0] resume_first,
  input wire logic [31:0] pause_second,
  input wire logic [31:0] modem_status,
  input wire logic [3:0]  dtr_n_r,
  input wire logic [3:0]  rts_n_r,
  input wire logic [3:0]  loopback_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // A read strobe starts while some channel is selected.
  sequence s_rd_start;
    $fell(rd_n) && (cs_n != 4'hF);
  endsequence
  // The read strobe has stayed released for four samples.
  sequence s_rd_quiet;
    rd_n [*4];
  endsequence
  // Channel zero wrote this transmit byte at the holding location three samples back.
  sequence s_hold_wr0;
    $past(cs_n[0], 3) == 1'b0 && $past(addr, 3) == 3'h0 &&
      tx_data[7:0] == $past(wdata, 3);
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  a_oe_follows_read: assert property (s_rd_start |-> ##[1:4] rdata_oe)
    else $error("read enable did not rise after a read strobe");
  a_oe_needs_read: assert property (s_rd_quiet |-> !rdata_oe)
    else $error("read enable high without a read strobe");
  a_tx_data_match: assert property (tx_load[0] |-> s_hold_wr0)
    else $error("transmit byte does not match the written byte");
  a_rx_pop_cause: assert property (rx_pop_r[0] |-> $past(rd_n, 2) == 1'b0 &&
      $past(cs_n[0], 2) == 1'b0 && $past(addr, 2) == 3'h0 && !line_ctl[7])
    else $error("receive pop without a standard read of address zero");
  a_fifo_load_cause: assert property (fifo_load[0] |-> $past(cs_n[0], 3) == 1'b0 &&
      $past(addr, 3) == 3'h2 && !line_ctl[7])
    else $error("FIFO control load without a standard write of address two");
  a_read_line_ctl: assert property ($rose(rdata_oe) && $past(addr, 2) == 3'h3 &&
      $past(cs_n, 2) == 4'hE |=> rdata_r == line_ctl[7:0])
    else $error("line control readback differs from stored value");
  a_gate_locked: assert property (!enh_feature[4] |-> int_enable[7:4] == 4'h0 &&
      fifo_ctl[5:4] == 2'h0 && modem_ctl[7:5] == 3'h0)
    else $error("gated bits visible while locked");
  a_frac_reserved: assert property ((div_frac & 32'hC0C0_C0C0) == 32'h0000_0000)
    else $error("reserved fraction bits set");
  a_reset_clears: assert property ($rose(rst_n) |-> int_enable == 32'h0000_0000 &&
      resume_first == 32'h0000_0000 && pause_second == 32'h0000_0000)
    else $error("registers not cleared by reset");
  a_modem_pins: assert property (!modem_ctl[4] && $stable(modem_ctl[4:0]) |->
      dtr_n_r[0] == !modem_ctl[0] && rts_n_r[0] == !modem_ctl[1])
    else $error("modem outputs do not follow modem control");
  a_cts_delta: assert property (!loopback_r[0] && $fell(cts_n[0]) |->
      ##[2:4] modem_status[0])
    else $error("clear-to-send change flag not raised");
  a_other_chan: assert property ((cs_n[3:1] == 3'h7) [*6] |-> tx_load[3:1] == 3'h0 &&
      $stable(int_enable[31:8]) && $stable(line_ctl[31:8]))
    else $error("unselected channel changed");
endmodule

bind ucrd_register_decode ucrd_decode_checker u_chk (.clock, .rst_n, .cs_n, .addr, .rd_n,
  .wdata, .rdata_r, .rdata_oe, .cts_n, .rx_pop_r, .tx_data, .tx_load, .fifo_load,
  .fifo_ctl, .int_enable, .line_ctl, .modem_ctl, .enh_feature, .div_frac, .resume_first,
  .pause_second, .modem_status, .dtr_n_r, .rts_n_r, .loopback_r);
`default_nettype wire

// [tb/ucrd_host_model.sv]
// Host processor model that drives the parallel register bus of the decoder.
`default_nettype none
module ucrd_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] rdata_r,
  output var  logic [3:0] cs_n,
  output var  logic [2:0] addr,
  output var  logic       wr_n,
  output var  logic       rd_n,
  output var  logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;

  //////////////////////////////////////////////////////////////////////////////
  // Bus idles with no channel selected and both strobes released.
  initial begin
    cs_n = 4'hF;
    addr = 3'h0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    wdata = 8'h00;
  end

  // One access: three clocks of setup, five of strobe, four of hold, then release.
  // The released data lines show the inverse so a stale byte is never reused.
  task automatic xfer(input logic w, input logic [1:0] ch, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    cs_n <= ~(4'h1 << ch);
    addr <= a;
    wdata <= d;
    repeat (3) @(posedge clock);
    wr_n <= ~w;
    rd_n <= w;
    repeat (5) @(posedge clock);
    q = rdata_r;
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (4) @(posedge clock);
    cs_n <= 4'hF;
    wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [tb/tb_uart_channel_register_decode.sv]
// Self-checking bench for the four-channel register decoder.
`default_nettype none
module tb_uart_channel_register_decode;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] line_control;
    logic [2:0] a;
    logic [7:0] w;
    logic [7:0] e;
  } ucrd_row_t;
  logic        clock;
  logic        rst_n;
  logic [3:0]  cs_n;
  logic [2:0]  addr;
  logic        wr_n;
  logic        rd_n;
  logic [7:0]  wdata;
  logic [7:0]  rdata_r;
  logic [31:0] rx_data;
  logic [31:0] isr_in;
  logic [31:0] lsr_in;
  logic [3:0]  cts_n;
  logic [31:0] tx_data;
  logic [31:0] int_enable;
  logic [31:0] resume_first;
  logic [3:0]  dtr_n_r;
  logic [3:0]  rts_n_r;
  logic [3:0]  interrupt_output_enable_r;
  logic [3:0]  reserved_user_output_r;
  logic [3:0]  loopback_r;
  logic [7:0]  got;
  int          errors;
  int          samples_checked;
  // Channel, mode value, address, written byte and expected readback.
  ucrd_row_t   rows [17] = '{
    '{2'h0, 8'h00, 3'h7, 8'hA5, 8'hA5}, '{2'h1, 8'h00, 3'h7, 8'h3C, 8'h3C},
    '{2'h0, 8'h00, 3'h1, 8'hFF, 8'h0F}, '{2'h0, 8'h00, 3'h4, 8'hEF, 8'h0F},
    '{2'h0, 8'h00, 3'h0, 8'h96, 8'h6B}, '{2'h0, 8'h00, 3'h2, 8'hFF, 8'hC1},
    '{2'h0, 8'h00, 3'h5, 8'h00, 8'h61}, '{2'h0, 8'h80, 3'h0, 8'h5A, 8'h5A},
    '{2'h0, 8'h80, 3'h1, 8'hC3, 8'hC3}, '{2'h0, 8'hBF, 3'h2, 8'h10, 8'h10},
    '{2'h0, 8'hBF, 3'h4, 8'h11, 8'h11}, '{2'h0, 8'hBF, 3'h5, 8'h22, 8'h22},
    '{2'h0, 8'hBF, 3'h6, 8'h33, 8'h33}, '{2'h0, 8'hBF, 3'h7, 8'h44, 8'h44},
    '{2'h0, 8'h80, 3'h2, 8'hFF, 8'h3F}, '{2'h0, 8'h00, 3'h1, 8'hFF, 8'hFF},
    '{2'h0, 8'hBF, 3'h1, 8'h77, 8'h00}};

  //////////////////////////////////////////////////////////////////////////////
  // The four modem pins share one drive so every status bit sees each change.
  ucrd_register_decode DUT (.clock, .rst_n, .cs_n, .addr, .wr_n, .rd_n, .wdata,
    .rdata_r, .rdata_oe(), .rx_data, .isr_in, .lsr_in, .cts_n, .dsr_n(cts_n),
    .ri_n(cts_n), .cd_n(cts_n), .rx_pop_r(), .tx_data, .tx_load(), .fifo_ctl(),
    .fifo_load(), .int_enable, .line_ctl(), .modem_ctl(), .enh_feature(), .div_low(),
    .div_high(), .div_frac(), .resume_first, .resume_second(), .pause_first(),
    .pause_second(), .modem_status(), .dtr_n_r, .rts_n_r,
    .interrupt_output_enable_r, .reserved_user_output_r, .loopback_r);
  ucrd_host_model HOST (.clock, .rdata_r, .cs_n, .addr, .wr_n, .rd_n, .wdata);

  //////////////////////////////////////////////////////////////////////////////
  // Compares one register value and counts the outcome.
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Free-running clock of 100 ns period.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Watchdog that cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of accesses, then the awkward cases.
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    rx_data = 32'h0000_006B;
    isr_in = 32'h0000_00C1;
    lsr_in = 32'h0000_0061;
    cts_n = 4'hF;
    repeat (16) @(posedge clock);
    check(int_enable, 32'h0000_0000);
    check(resume_first, 32'h0000_0000);
    rst_n <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      HOST.xfer(1'b1, rows[i].ch, 3'h3, rows[i].line_control, got);
      HOST.xfer(1'b1, rows[i].ch, rows[i].a, rows[i].w, got);
      HOST.xfer(1'b0, rows[i].ch, 3'h3, 8'h00, got);
      check(got, rows[i].line_control);
      HOST.xfer(1'b0, rows[i].ch, rows[i].a, 8'h00, got);
      check(got, rows[i].e);
      $display("test row %0d done", i);
    end
    check(tx_data, 32'h0000_0096);
    check(int_enable, 32'h0000_00FF);
    check({dtr_n_r, rts_n_r}, 8'hEE);
    check({interrupt_output_enable_r, reserved_user_output_r}, 8'h11);
    $display("test side outputs done");
    HOST.xfer(1'b1, 2'h0, 3'h3, 8'h00, got);
    cts_n <= 4'hE;
    repeat (6) @(posedge clock);
    HOST.xfer(1'b0, 2'h0, 3'h6, 8'h00, got);
    check(got, 8'hFF);
    HOST.xfer(1'b0, 2'h0, 3'h6, 8'h00, got);
    check(got, 8'hF0);
    $display("test modem status done");
    HOST.xfer(1'b1, 2'h0, 3'h4, 8'h13, got);
    check({dtr_n_r, rts_n_r, loopback_r}, 12'hFF1);
    HOST.xfer(1'b0, 2'h0, 3'h6, 8'h00, got);
    check(got, 8'h3C);
    $display("test loopback done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    check(resume_first, 32'h0000_0000);
    check(int_enable, 32'h0000_0000);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    $display("test second reset done");
    close_out;
  end
endmodule
`default_nettype wire
